// *** logic/fsp_pkg.sv ***
package fsp_pkg;
	// array geometry
	localparam int ADDR_W    = 13;
	localparam int DATA_W    = 8;
	localparam int MEM_DEPTH = 8192;
	// command codes
	localparam logic [7:0] OP_WRITE_LATCH_SET   = 8'h06;
	localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_STATUS_READ       = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE      = 8'h01;
	localparam logic [7:0] OP_MEM_READ          = 8'h03;
	localparam logic [7:0] OP_MEM_WRITE         = 8'h02;
	// status byte layout
	localparam int SR_GUARD_BIT = 7;
	localparam int SR_BP_HI     = 3;
	localparam int SR_BP_LO     = 2;
	localparam int SR_WEL_BIT   = 1;
	// reset values
	localparam logic [1:0] BP_RESET    = 2'h0;
	localparam logic       GUARD_RESET = 1'b0;
	localparam logic       WEL_RESET   = 1'b0;
	// block protect encodings
	localparam logic [1:0] BP_NONE    = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF    = 2'h2;
	localparam logic [1:0] BP_ALL     = 2'h3;
	// interface phases, gray along cmd, addr, data
	typedef enum logic [1:0] {
		ST_CMD    = 2'h0,
		ST_ADDR   = 2'h1,
		ST_DATA   = 2'h3,
		ST_IGNORE = 2'h2
	} fsp_state_t;
endpackage

// *** logic/fsp_mem.sv ***
`timescale 1ns/100ps
module fsp_mem #(
	parameter int ADDR_W = fsp_pkg::ADDR_W,
	parameter int DATA_W = fsp_pkg::DATA_W
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	output logic      [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// byte write, takes effect on the same edge
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wr_data;
		end
	end

	// registered read, one cycle behind the address
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[addr];
		end
	end
endmodule

// *** logic/fsp_spi_slave.sv ***
`timescale 1ns/100ps
module fsp_spi_slave (
	input  wire logic MCLK,
	input  wire logic NRST,
	input  wire logic CS_N,
	input  wire logic SCK,
	input  wire logic SI,
	input  wire logic WP_N,
	input  wire logic HOLD_N,
	output logic      SO,
	output logic      SO_OE
);
	localparam int AW = fsp_pkg::ADDR_W;

	// two-stage synchronisers for all pins
	logic       cs_m, cs_s, sck_m, sck_s, sck_d;
	logic       si_m, si_s, wp_m, wp_s, hold_m, hold_s;
	logic       run, sck_rise, sck_fall, byte_done, cs_rise;
	logic       cs_d;
	logic [2:0] bit_cnt_reg;
	logic [7:0] shift_reg, new_byte, cmd_reg, tx_byte, status_byte;
	logic [7:0] mem_rd;
	logic [AW-1:0] addr_reg;
	logic       addr_hi_reg, wel_reg, guard_reg, oe_reg, so_reg;
	logic       mem_we, sr_wr_ok, is_read;
	logic [1:0] bp_reg;
	fsp_pkg::fsp_state_t state_reg;

	// write-protect decode for an address
	function automatic logic prot(input logic [1:0] bp,
		input logic [AW-1:0] a);
		case (bp)
			fsp_pkg::BP_QUARTER: prot = &a[AW-1:AW-2];
			fsp_pkg::BP_HALF:    prot = a[AW-1];
			fsp_pkg::BP_ALL:     prot = 1'b1;
			default:             prot = 1'b0;
		endcase
	endfunction

	// pin synchronisers
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			{cs_m, cs_s, cs_d}     <= 3'h7;
			{sck_m, sck_s, sck_d}  <= 3'h0;
			{si_m, si_s}           <= 2'h0;
			{wp_m, wp_s}           <= 2'h3;
			{hold_m, hold_s}       <= 2'h3;
		end else begin
			cs_m   <= CS_N;
			cs_s   <= cs_m;
			cs_d   <= cs_s;
			sck_m  <= SCK;
			sck_s  <= sck_m;
			sck_d  <= sck_s;
			si_m   <= SI;
			si_s   <= si_m;
			wp_m   <= WP_N;
			wp_s   <= wp_m;
			hold_m <= HOLD_N;
			hold_s <= hold_m;
		end
	end

	// gated clock edges, pause and deselect mask them
	assign run       = !cs_s && hold_s;
	assign sck_rise  = run && sck_s && !sck_d;
	assign sck_fall  = run && !sck_s && sck_d;
	assign cs_rise   = hold_s && cs_s && !cs_d;
	assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);
	assign new_byte  = {shift_reg[6:0], si_s};
	assign is_read   = (cmd_reg == fsp_pkg::OP_MEM_READ) ||
		(cmd_reg == fsp_pkg::OP_STATUS_READ);

	// bit counter and input shifter
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			bit_cnt_reg <= 3'h0;
			shift_reg   <= 8'h00;
		end else if (hold_s) begin
			if (cs_s) begin
				bit_cnt_reg <= 3'h0;
			end else if (sck_rise) begin
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				shift_reg   <= new_byte;
			end
		end
	end

	// phase machine
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			state_reg   <= fsp_pkg::ST_CMD;
			cmd_reg     <= 8'h00;
			addr_hi_reg <= 1'b0;
		end else if (hold_s) begin
			if (cs_s) begin
				state_reg   <= fsp_pkg::ST_CMD;
				addr_hi_reg <= 1'b0;
			end else if (byte_done) begin
				case (state_reg)
					fsp_pkg::ST_CMD: begin
						cmd_reg <= new_byte;
						case (new_byte)
							fsp_pkg::OP_MEM_READ,
							fsp_pkg::OP_MEM_WRITE:
								state_reg <= fsp_pkg::ST_ADDR;
							fsp_pkg::OP_STATUS_READ,
							fsp_pkg::OP_STATUS_WRITE:
								state_reg <= fsp_pkg::ST_DATA;
							default:
								state_reg <= fsp_pkg::ST_IGNORE;
						endcase
					end
					fsp_pkg::ST_ADDR: begin
						addr_hi_reg <= 1'b1;
						if (addr_hi_reg) begin
							state_reg <= fsp_pkg::ST_DATA;
						end
					end
					default: begin
						state_reg <= state_reg;
					end
				endcase
			end
		end
	end

	// address capture and auto increment
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			addr_reg <= '0;
		end else if (hold_s && !cs_s && byte_done) begin
			if (state_reg == fsp_pkg::ST_ADDR) begin
				if (addr_hi_reg) begin
					addr_reg[7:0] <= new_byte;
				end else begin
					addr_reg[AW-1:8] <= new_byte[AW-9:0];
				end
			end else if (state_reg == fsp_pkg::ST_DATA &&
				cmd_reg != fsp_pkg::OP_STATUS_READ &&
				cmd_reg != fsp_pkg::OP_STATUS_WRITE) begin
				addr_reg <= addr_reg + 1'b1;
			end
		end
	end

	// array write at the eighth bit, no busy time
	assign mem_we = byte_done && state_reg == fsp_pkg::ST_DATA &&
		cmd_reg == fsp_pkg::OP_MEM_WRITE && wel_reg &&
		!prot(bp_reg, addr_reg);

	// status writes need the latch and pass the pin guard
	assign sr_wr_ok = byte_done && state_reg == fsp_pkg::ST_DATA &&
		cmd_reg == fsp_pkg::OP_STATUS_WRITE && wel_reg &&
		!(!wp_s && guard_reg);

	// write latch
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			wel_reg <= fsp_pkg::WEL_RESET;
		end else if (byte_done && state_reg == fsp_pkg::ST_CMD) begin
			if (new_byte == fsp_pkg::OP_WRITE_LATCH_SET) begin
				wel_reg <= 1'b1;
			end else if (new_byte == fsp_pkg::OP_WRITE_LATCH_CLEAR) begin
				wel_reg <= 1'b0;
			end
		end
	end

	// status fields
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			guard_reg <= fsp_pkg::GUARD_RESET;
			bp_reg    <= fsp_pkg::BP_RESET;
		end else if (sr_wr_ok) begin
			guard_reg <= new_byte[fsp_pkg::SR_GUARD_BIT];
			bp_reg    <= new_byte[fsp_pkg::SR_BP_HI:fsp_pkg::SR_BP_LO];
		end
	end

	// read byte source
	always_comb begin
		status_byte = 8'h00;
		status_byte[fsp_pkg::SR_GUARD_BIT] = guard_reg;
		status_byte[fsp_pkg::SR_BP_HI:fsp_pkg::SR_BP_LO] = bp_reg;
		status_byte[fsp_pkg::SR_WEL_BIT] = wel_reg;
		if (cmd_reg == fsp_pkg::OP_STATUS_READ) begin
			tx_byte = status_byte;
		end else begin
			tx_byte = mem_rd;
		end
	end

	// output bit changes and enable rises on falling edges, enable drops at once on deselect
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			so_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else if (hold_s) begin
			if (cs_s || state_reg != fsp_pkg::ST_DATA || !is_read) begin
				oe_reg <= 1'b0;
			end else if (sck_fall) begin
				oe_reg <= 1'b1;
				so_reg <= tx_byte[3'h7 - bit_cnt_reg];
			end
		end
	end

	assign SO    = so_reg;
	assign SO_OE = oe_reg && run;

	fsp_mem #(
		.ADDR_W (fsp_pkg::ADDR_W),
		.DATA_W (fsp_pkg::DATA_W)
	) u_mem (
		.clk     (MCLK),
		.rst_n   (NRST),
		.we      (mem_we),
		.addr    (addr_reg),
		.wr_data (new_byte),
		.rd_data (mem_rd)
	);

	// checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	sequence s_cmd_end(logic [7:0] op);
		byte_done && state_reg == fsp_pkg::ST_CMD && new_byte == op;
	endsequence

	chk_deselect_quiet: assert property (
		cs_s && hold_s |=> !oe_reg && !SO_OE)
		else $error("output enabled while deselected");
	chk_pause_quiet: assert property (
		!hold_s |-> !SO_OE ##1 $stable(so_reg))
		else $error("output enabled or moved during pause");
	chk_ignore_quiet: assert property (
		state_reg == fsp_pkg::ST_IGNORE |-> !SO_OE)
		else $error("output enabled after unknown command");
	chk_byte_commit: assert property (
		byte_done && state_reg == fsp_pkg::ST_DATA && wel_reg &&
		cmd_reg == fsp_pkg::OP_MEM_WRITE && !prot(bp_reg, addr_reg)
		|-> mem_we ##1 (addr_reg == $past(addr_reg) + 1'b1))
		else $error("write byte not committed");
	chk_latch_clear: assert property (
		s_cmd_end(fsp_pkg::OP_WRITE_LATCH_CLEAR) |=> !wel_reg)
		else $error("latch still set after clear command");
	chk_latch_gate: assert property (
		!wel_reg |-> !mem_we && !sr_wr_ok)
		else $error("write allowed with latch clear");
	chk_guard_block: assert property (
		byte_done && cmd_reg == fsp_pkg::OP_STATUS_WRITE && !wp_s &&
		guard_reg |=> $stable(bp_reg) && guard_reg)
		else $error("status written while guarded");
	chk_deselect_idle: assert property (
		cs_rise |=> state_reg == fsp_pkg::ST_CMD && bit_cnt_reg == 3'h0)
		else $error("partial byte kept after deselect");
	chk_pause_freeze: assert property (
		!hold_s |=> $stable(state_reg) && $stable(bit_cnt_reg) &&
		$stable(shift_reg))
		else $error("state moved during pause");
	chk_rise_sample: assert property (
		!sck_rise |=> $stable(shift_reg))
		else $error("input taken without rising edge");
	chk_fall_drive: assert property (
		$changed(so_reg) |-> $past(sck_fall))
		else $error("output bit changed off a falling edge");
endmodule

// *** sim/fsp_master.sv ***
`timescale 1ns/100ps
// behavioural link master, drives pins just after mclk falls
module fsp_master (
	input  wire logic mclk,
	input  wire logic so_line,
	input  wire logic so_oe,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      hold_n
);
	logic cpol;
	logic oe_seen;
	// idle pins
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
		cpol = 1'b0;
		oe_seen = 1'b0;
	end
	// half a link clock period
	task automatic hc();
		repeat (4) @(negedge mclk);
	endtask
	// fresh selection per command, clock parked at idle
	task automatic sel(input logic mode3);
		cpol = mode3;
		sck = mode3;
		hc();
		cs_n = 1'b0;
		oe_seen = 1'b0;
		hc();
	endtask
	// one byte each way, msb first, read at end of high phase
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			hc();
			sck = 1'b1;
			hc();
			rx[i] = so_line;
			oe_seen = oe_seen | so_oe;
		end
		sck = cpol;
		hc();
	endtask
	// leading n bits of a byte only, clock left high
	task automatic part(input logic [7:0] tx, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			sck = 1'b0;
			si = tx[i];
			hc();
			sck = 1'b1;
			hc();
		end
	endtask
	// end of selection, data line flipped so stale bits cannot help
	task automatic desel();
		cs_n = 1'b1;
		si = ~si;
		hc();
	endtask
	// pause entered and left with clock low, clock wiggled meanwhile
	task automatic pause();
		hold_n = 1'b0;
		hc();
		oe_seen = so_oe;
		repeat (3) begin
			sck = 1'b1;
			hc();
			sck = 1'b0;
			oe_seen = oe_seen | so_oe;
			hc();
		end
		hold_n = 1'b1;
		hc();
	endtask
endmodule

// *** sim/fsp_spi_slave_bench.sv ***
`timescale 1ns/100ps
module fsp_spi_slave_bench;
	logic       mclk, nrst, wp_n, so, so_oe;
	wire logic  cs_n, sck, si, hold_n, so_line;
	logic [7:0] rd [4];
	logic [7:0] r;
	logic [15:0] pa [4];
	int         checks, mismatches;
	// released line shows the inverse of the last bit
	assign so_line = so_oe ? so : !so;
	fsp_spi_slave u_fsp_spi_slave (.MCLK(mclk), .NRST(nrst), .CS_N(cs_n),
		.SCK(sck), .SI(si), .WP_N(wp_n), .HOLD_N(hold_n), .SO(so),
		.SO_OE(so_oe));
	fsp_master u_fsp_master (.mclk(mclk), .so_line(so_line), .so_oe(so_oe),
		.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// single byte command
	task automatic cmd(input logic [7:0] c);
		u_fsp_master.sel(1'b0);
		u_fsp_master.xfer(c, r);
		u_fsp_master.desel();
	endtask
	// memory access, n data bytes counting up from d
	task automatic mem(input logic m3, input logic [7:0] c,
		input logic [15:0] a, input logic [7:0] d, input int n);
		u_fsp_master.sel(m3);
		u_fsp_master.xfer(c, r);
		u_fsp_master.xfer(a[15:8], r);
		u_fsp_master.xfer(a[7:0], r);
		for (int i = 0; i < n; i++) begin
			u_fsp_master.xfer(d + 8'(i), rd[i]);
		end
		u_fsp_master.desel();
		chk8({7'h0, so_oe}, 8'h0);
	endtask
	// status command with one data byte
	task automatic sr(input logic [7:0] c, input logic [7:0] d);
		u_fsp_master.sel(1'b0);
		u_fsp_master.xfer(c, r);
		u_fsp_master.xfer(d, rd[0]);
		u_fsp_master.desel();
	endtask
	// write across top of array, read back in mode 3 at once
	task automatic t_wrap();
		cmd(8'h06);
		mem(1'b0, 8'h02, 16'hfffe, 8'ha0, 3);
		mem(1'b1, 8'h03, 16'h1ffe, 8'h00, 3);
		chk8(rd[0], 8'ha0);
		chk8(rd[1], 8'ha1);
		chk8(rd[2], 8'ha2);
	endtask
	// each block protect code guards its lowest protected byte
	task automatic t_prot();
		pa = '{16'h0000, 16'h1800, 16'h1000, 16'h0000};
		for (int q = 1; q < 4; q++) begin
			mem(1'b0, 8'h02, pa[q], 8'h11, 1);
		end
		for (int q = 1; q < 4; q++) begin
			sr(8'h01, 8'(q << 2));
			mem(1'b0, 8'h02, pa[q], 8'h55, 1);
			mem(1'b0, 8'h03, pa[q], 8'h00, 1);
			chk8(rd[0], 8'h11);
		end
		sr(8'h05, 8'h00);
		chk8(rd[0], 8'h0e);
		sr(8'h01, 8'h00);
	endtask
	// protect pin with guard bit set blocks status writes
	task automatic t_guard();
		sr(8'h01, 8'h80);
		wp_n = 1'b0;
		sr(8'h01, 8'h0c);
		sr(8'h05, 8'h00);
		chk8(rd[0], 8'h82);
		wp_n = 1'b1;
		sr(8'h01, 8'h00);
		sr(8'h05, 8'h00);
		chk8(rd[0], 8'h02);
	endtask
	// latch clear blocks memory and status writes
	task automatic t_clear();
		cmd(8'h04);
		mem(1'b0, 8'h02, 16'h0000, 8'h77, 1);
		sr(8'h01, 8'h0c);
		mem(1'b0, 8'h03, 16'h0000, 8'h00, 1);
		chk8(rd[0], 8'h11);
		// cut latch-set byte must be dropped, next command starts fresh
		u_fsp_master.sel(1'b0);
		u_fsp_master.part(8'h06, 5);
		u_fsp_master.desel();
		sr(8'h05, 8'h00);
		chk8(rd[0], 8'h00);
		cmd(8'h06);
	endtask
	// unknown code followed by a read pattern never drives output
	task automatic t_bad();
		u_fsp_master.sel(1'b0);
		u_fsp_master.xfer(8'hff, r);
		u_fsp_master.xfer(8'h03, r);
		u_fsp_master.xfer(8'h1f, r);
		u_fsp_master.xfer(8'hfe, r);
		u_fsp_master.xfer(8'h00, r);
		chk8({7'h0, u_fsp_master.oe_seen}, 8'h0);
		u_fsp_master.desel();
	endtask
	// pause between read bytes, wiggled clock must not advance
	task automatic t_pause();
		u_fsp_master.sel(1'b0);
		u_fsp_master.xfer(8'h03, r);
		u_fsp_master.xfer(8'h1f, r);
		u_fsp_master.xfer(8'hfe, r);
		u_fsp_master.xfer(8'h00, r);
		chk8(r, 8'ha0);
		u_fsp_master.pause();
		chk8({7'h0, u_fsp_master.oe_seen}, 8'h0);
		u_fsp_master.xfer(8'h00, r);
		chk8(r, 8'ha1);
		u_fsp_master.desel();
	endtask
	// reset then scenarios
	initial begin
		nrst = 1'b0;
		wp_n = 1'b1;
		checks = 0;
		mismatches = 0;
		repeat (12) @(negedge mclk);
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
		t_wrap();
		t_prot();
		t_guard();
		t_clear();
		t_bad();
		t_pause();
		wrap_up();
	end
	// hang guard, runs are about 170 us
	initial begin
		#1000000;
		mismatches++;
		wrap_up();
	end
endmodule
